// File: core/vc12_prot_pkg.sv
// package for the vc-12 1+1 dual-ended trail protection block
// assumes a single 100 mhz clock and a wishbone classic register bus
package vc12_prot_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00; // mode, report enable
  localparam logic [7:0] REG_WTR     = 8'h04; // wait to restore, seconds
  localparam logic [7:0] REG_HOLD    = 8'h08; // hold-off, 100 ms steps
  localparam logic [7:0] REG_CMD     = 8'h0C; // external command
  localparam logic [7:0] REG_STATUS  = 8'h10; // live state
  localparam logic [7:0] REG_IRQ_ST  = 8'h14; // sticky events (ro)
  localparam logic [7:0] REG_IRQ_EN  = 8'h18; // event enable
  localparam logic [7:0] REG_IRQ_CLR = 8'h1C; // write one to clear (wo)
  localparam logic [7:0] REG_APS_TX  = 8'h20; // protocol nibble to send
  localparam logic [7:0] REG_APS_RX  = 8'h24; // accepted far nibble

  // field positions
  localparam int CTRL_REVERT = 0;
  localparam int CTRL_REPORT = 1;
  localparam int NUM_EVT     = 4;
  localparam int EVT_SWITCH  = 0;
  localparam int EVT_WFAIL   = 1;
  localparam int EVT_PFAIL   = 2;
  localparam int EVT_APS     = 3;

  // reset values and limits
  localparam logic [15:0] WTR_RESET  = 16'h012C; // 300 s
  localparam logic [6:0]  HOLD_RESET = 7'h00;
  localparam logic [6:0]  HOLD_MAX   = 7'h64;    // 100 steps = 10 s
  localparam logic [15:0] WTR_MIN    = 16'h012C; // 5 min
  localparam logic [15:0] WTR_MAX    = 16'h02D0; // 12 min

  // timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int HOLD_STEP_MS = 100;
  localparam int HOLD_STEP_CY = CLK_HZ / 1000 * HOLD_STEP_MS;
  localparam int SEC_CY       = CLK_HZ;
  localparam int APS_PERSIST  = 3;  // repeats after a new nibble's first frame before accepting

  // external command codes
  typedef enum logic [3:0] {
    CMD_CLEAR   = 4'h0,
    CMD_BARRED  = 4'h1,   // lockout of protection / forced to working
    CMD_FORCE_P = 4'h2,
    CMD_FORCE_W = 4'h3,
    CMD_MAN_P   = 4'h4,
    CMD_MAN_W   = 4'h5,
    CMD_DRILL_W = 4'h6,
    CMD_DRILL_P = 4'h7
  } ext_cmd_t;

  // one path of a vc-12 signal
  typedef struct packed {
    logic [7:0] data;
    logic       clk;
    logic       frame;
  } path_sig_t;

  // fail / degrade flags of one path
  typedef struct packed {
    logic fail;
    logic degrade;
  } path_flags_t;
endpackage : vc12_prot_pkg

// File: core/vc12_prot.sv
// vc-12 1+1 dual-ended trail protection: connection, termination and
// adaptation functions with a wishbone classic register slave.
// assumes path signals arrive with their own clock/frame as pins that
// are sampled by clk_i; the overhead byte appears once per frame start.
`timescale 1ns/10ps

// What this block does
// - sink side forwards working or protection, chosen by flags and commands
// - source side bridges the normal input onto the working output
// - timer changes never disturb traffic while idle; a change to revertive mode reverts an idle protection selection at once
// - 1+1 bidirectional, ends agree through a channel on protection path
// - wait-to-restore settable about five to twelve minutes
// - hold-off zero to ten seconds in 100 ms steps
// - switch conditions come from upstream fail and degrade flags
// - revertive mode accepts lockout, force to protection, manual to protection, clear
// - non-revertive accepts lockout, force, manual, drill either path, clear
// - protection termination source passes data, clock, frame unchanged
// - termination sink reports the protected trail state
// - termination sink fail action follows incoming server fail
// - adaptation source merges protocol channel and data into one stream
// - protocol channel inserted into overhead only on protection path
// - adaptation sink recovers data with clock and frame start
// - protocol channel extracted and persistence checked on protection
module vc12_prot
  import vc12_prot_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o,
  // normal point input (source) and output (sink)
  input  wire path_sig_t   norm_in_i,
  output path_sig_t        norm_out_o,
  output logic             norm_fail_o,
  // working path: access point in/out plus upstream flags
  input  wire path_sig_t   work_in_i,
  input  wire path_flags_t work_flags_i,
  output path_sig_t        work_out_o,
  // protection path: access point in/out plus upstream flags
  input  wire path_sig_t   prot_in_i,
  input  wire path_flags_t prot_flags_i,
  output path_sig_t        prot_out_o,
  // protected trail report toward the vc-12 layer
  output logic             trail_fail_action_o,
  output logic             server_fail_report_o
);
  localparam int HS_W = $clog2(HOLD_STEP_CY + 1);
  localparam int SC_W = $clog2(SEC_CY + 1);

  // ---------------------------------------------------------------
  // pin synchronisers (two flops on every path and flag input)
  // ---------------------------------------------------------------
  path_sig_t   norm_m, norm_s, work_m, work_s, prot_m, prot_s;
  path_flags_t wf_m, wf_s, pf_m, pf_s;
  always_ff @(posedge clk_i) begin
    norm_m <= norm_in_i;
    norm_s <= norm_m;
    work_m <= work_in_i;
    work_s <= work_m;
    prot_m <= prot_in_i;
    prot_s <= prot_m;
    wf_m   <= work_flags_i;
    wf_s   <= wf_m;
    pf_m   <= prot_flags_i;
    pf_s   <= pf_m;
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic                revert_mode_select;
  logic                server_fail_report_enable;
  logic [15:0]         wait_restore_delay;
  logic [6:0]          holdoff_delay;
  ext_cmd_t            external_command;
  logic                cmd_pulse;
  logic [3:0]          aps_tx;
  logic [3:0]          aps_rx;
  logic [NUM_EVT-1:0]  evt_sticky, evt_en, evt_pulse, clr_bits;
  logic                sel_prot;
  logic                wtr_run;
  logic                bus_req;
  logic                wr_hit;

  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_hit  = bus_req && we_i && sel_i[0];
  assign clr_bits = (wr_hit && adr_i == REG_IRQ_CLR)
                    ? dat_i[NUM_EVT-1:0] : '0;

  // one-cycle ack; config writes set mode, timers and enables, and a REG_CMD write can move the selector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o                     <= 1'b0;
      dat_o                     <= 32'h0000_0000;
      revert_mode_select        <= 1'b1;
      server_fail_report_enable <= 1'b0;
      wait_restore_delay        <= WTR_RESET;
      holdoff_delay             <= HOLD_RESET;
      external_command          <= CMD_CLEAR;
      cmd_pulse                 <= 1'b0;
      aps_tx                    <= 4'h0;
      evt_en                    <= '0;
    end else begin
      ack_o     <= bus_req;
      cmd_pulse <= 1'b0;
      if (wr_hit) begin
        case (adr_i)
          REG_CTRL: begin
            revert_mode_select        <= dat_i[CTRL_REVERT];
            server_fail_report_enable <= dat_i[CTRL_REPORT];
          end
          REG_WTR: begin // clamp into the allowed window
            if (dat_i[15:0] < WTR_MIN)
              wait_restore_delay <= WTR_MIN;
            else if (dat_i[15:0] > WTR_MAX)
              wait_restore_delay <= WTR_MAX;
            else
              wait_restore_delay <= dat_i[15:0];
          end
          REG_HOLD: holdoff_delay <= (dat_i[6:0] > HOLD_MAX)
                                     ? HOLD_MAX : dat_i[6:0];
          REG_CMD: begin
            external_command <= ext_cmd_t'(dat_i[3:0]);
            cmd_pulse        <= 1'b1;
          end
          REG_APS_TX: aps_tx <= dat_i[3:0];
          REG_IRQ_EN: evt_en <= dat_i[NUM_EVT-1:0];
          default: ;
        endcase
      end
      case (adr_i)
        REG_CTRL:   dat_o <= {30'h0, server_fail_report_enable,
                              revert_mode_select};
        REG_WTR:    dat_o <= {16'h0000, wait_restore_delay};
        REG_HOLD:   dat_o <= {25'h0, holdoff_delay};
        REG_CMD:    dat_o <= {28'h000_0000, external_command};
        REG_STATUS: dat_o <= {26'h0, wtr_run, pf_s.fail, wf_s.degrade,
                              wf_s.fail, sel_prot, 1'b0};
        REG_IRQ_ST: dat_o <= {28'h000_0000, evt_sticky};
        REG_IRQ_EN: dat_o <= {28'h000_0000, evt_en};
        REG_APS_TX: dat_o <= {28'h000_0000, aps_tx};
        REG_APS_RX: dat_o <= {28'h000_0000, aps_rx};
        default:    dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // timebase: 100 ms step and 1 s tick enables
  // ---------------------------------------------------------------
  logic [HS_W-1:0] step_cnt;
  logic [SC_W-1:0] sec_cnt;
  logic            step_tick, sec_tick;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_cnt  <= '0;
      sec_cnt   <= '0;
      step_tick <= 1'b0;
      sec_tick  <= 1'b0;
    end else begin
      step_tick <= (step_cnt == HS_W'(HOLD_STEP_CY - 1));
      sec_tick  <= (sec_cnt == SC_W'(SEC_CY - 1));
      step_cnt  <= (step_cnt == HS_W'(HOLD_STEP_CY - 1))
                   ? '0 : step_cnt + 1'b1;
      sec_cnt   <= (sec_cnt == SC_W'(SEC_CY - 1))
                   ? '0 : sec_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // hold-off: a condition acts only after it persists the set time
  // ---------------------------------------------------------------
  logic [6:0] ho_w, ho_p;
  logic       w_cond, p_cond, w_act, p_act;
  assign w_cond = wf_s.fail || wf_s.degrade;
  assign p_cond = pf_s.fail || pf_s.degrade;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ho_w  <= 7'h00;
      ho_p  <= 7'h00;
      w_act <= 1'b0;
      p_act <= 1'b0;
    end else begin
      // zero hold-off acts at once; clearing is never held off
      if (!w_cond) begin
        ho_w  <= 7'h00;
        w_act <= 1'b0;
      end else if (ho_w >= holdoff_delay) begin
        w_act <= 1'b1;
      end else if (step_tick) begin
        ho_w <= ho_w + 7'h01;
      end
      if (!p_cond) begin
        ho_p  <= 7'h00;
        p_act <= 1'b0;
      end else if (ho_p >= holdoff_delay) begin
        p_act <= 1'b1;
      end else if (step_tick) begin
        ho_p <= ho_p + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // command filter and selector decision
  // ---------------------------------------------------------------
  ext_cmd_t held_cmd;
  logic     cmd_ok;
  // revertive mode accepts only a subset of commands
  always_comb begin
    if (revert_mode_select)
      cmd_ok = (external_command == CMD_CLEAR)   ||
               (external_command == CMD_BARRED)  ||
               (external_command == CMD_FORCE_P) ||
               (external_command == CMD_MAN_P);
    else
      cmd_ok = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      held_cmd <= CMD_CLEAR;
    else if (cmd_pulse && cmd_ok)
      held_cmd <= external_command;
  end

  // wait-to-restore counter in seconds
  logic [15:0] wtr_cnt;
  logic        w_act_d;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wtr_run <= 1'b0;
      wtr_cnt <= 16'h0000;
      w_act_d <= 1'b0;
    end else begin
      w_act_d <= w_act;
      if (!revert_mode_select || w_act) begin
        wtr_run <= 1'b0;
        wtr_cnt <= 16'h0000;
      end else if (w_act_d && sel_prot) begin
        wtr_run <= 1'b1; // restart after each working failure
        wtr_cnt <= 16'h0000;
      end else if (wtr_run && sec_tick) begin
        if (wtr_cnt + 16'h0001 >= wait_restore_delay)
          wtr_run <= 1'b0;
        wtr_cnt <= wtr_cnt + 16'h0001;
      end
    end
  end

  // priority: lockout > forced > signal fail > manual > far-end request > wtr
  logic next_sel;
  logic far_prot;
  always_comb begin
    next_sel = sel_prot;
    case (held_cmd)
      CMD_BARRED:  next_sel = 1'b0;
      CMD_FORCE_P: next_sel = 1'b1;
      CMD_FORCE_W: next_sel = 1'b0;
      default: begin
        if (w_act && !p_act)
          next_sel = 1'b1;
        else if (p_act && !w_act)
          next_sel = 1'b0;
        else if (held_cmd == CMD_MAN_P)
          next_sel = 1'b1;
        else if (held_cmd == CMD_MAN_W)
          next_sel = 1'b0;
        else if (far_prot != sel_prot)
          next_sel = far_prot; // follow the far-end request
        else if (revert_mode_select && sel_prot && !wtr_run && !w_act
                 && !w_act_d)
          next_sel = 1'b0;
      end
    endcase
  end

  // selector updates in one cycle, well inside 50 ms
  always_ff @(posedge clk_i) begin
    if (rst_i)
      sel_prot <= 1'b0;
    else
      sel_prot <= next_sel;
  end

  // ---------------------------------------------------------------
  // protocol channel on the protection path overhead byte
  // ---------------------------------------------------------------
  logic [3:0] aps_cand;
  logic [1:0] aps_same;
  logic       prot_frame_d;
  assign far_prot = aps_rx[0];
  // frame-start edge found by sampling the synchronised frame pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prot_frame_d <= 1'b0;
      aps_cand     <= 4'h0;
      aps_same     <= 2'b00;
      aps_rx       <= 4'h0;
    end else begin
      prot_frame_d <= prot_s.frame;
      if (prot_s.frame && !prot_frame_d) begin
        if (prot_s.data[7:4] == aps_cand) begin
          if (aps_same == 2'(APS_PERSIST - 1))
            aps_rx <= aps_cand;
          else
            aps_same <= aps_same + 2'b01;
        end else begin
          aps_cand <= prot_s.data[7:4];
          aps_same <= 2'b00;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // data paths and trail report
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      norm_out_o           <= '0;
      norm_fail_o          <= 1'b0;
      work_out_o           <= '0;
      prot_out_o           <= '0;
      trail_fail_action_o  <= 1'b0;
      server_fail_report_o <= 1'b0;
    end else begin
      norm_out_o  <= sel_prot ? prot_s : work_s;
      norm_fail_o <= sel_prot ? pf_s.fail : wf_s.fail;
      work_out_o  <= norm_s;
      prot_out_o  <= norm_s;
      if (norm_s.frame) // tx nibble bits 3:1 with own selector bit as bit 0
        prot_out_o.data[7:4] <= {aps_tx[3:1], sel_prot};
      // protected trail fails only when the selected trail fails
      trail_fail_action_o  <= sel_prot ? pf_s.fail : wf_s.fail;
      server_fail_report_o <= (sel_prot ? pf_s.fail : wf_s.fail)
                              && server_fail_report_enable;
    end
  end

  // ---------------------------------------------------------------
  // interrupts: sticky events, set beats clear
  // ---------------------------------------------------------------
  logic sel_d, pf_d;
  logic [3:0] aps_rx_d;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_d      <= 1'b0;
      pf_d       <= 1'b0;
      aps_rx_d   <= 4'h0;
      evt_sticky <= '0;
      irq_o      <= 1'b0;
    end else begin
      sel_d      <= sel_prot;
      pf_d       <= p_act;
      aps_rx_d   <= aps_rx;
      evt_sticky <= (evt_sticky & ~clr_bits) | evt_pulse;
      irq_o      <= |(evt_sticky & evt_en);
    end
  end
  always_comb begin
    evt_pulse             = '0;
    evt_pulse[EVT_SWITCH] = sel_d != sel_prot;
    evt_pulse[EVT_WFAIL]  = w_act && !w_act_d;
    evt_pulse[EVT_PFAIL]  = p_act && !pf_d;
    evt_pulse[EVT_APS]    = aps_rx != aps_rx_d;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_fail_selects_prot: assert property (@(posedge clk_i) disable iff
    (rst_i) (w_act && !p_act && held_cmd == CMD_CLEAR) |=> sel_prot)
    else $error("working fail did not select protection");
  chk_lockout_holds_w: assert property (@(posedge clk_i) disable iff
    (rst_i) held_cmd == CMD_BARRED |=> !sel_prot)
    else $error("lockout left protection selected");
  chk_bridge_work: assert property (@(posedge clk_i) disable iff
    (rst_i) 1'b1 |=> work_out_o == $past(norm_s))
    else $error("working output not bridged from normal");
  chk_prot_pass_clk: assert property (@(posedge clk_i) disable iff
    (rst_i) 1'b1 |=> prot_out_o.clk == $past(norm_s.clk))
    else $error("protection clock not passed through");
  chk_report_gate: assert property (@(posedge clk_i) disable iff
    (rst_i) !server_fail_report_enable |=> !server_fail_report_o)
    else $error("fail reported while disabled");
  chk_tsf_follow: assert property (@(posedge clk_i) disable iff
    (rst_i) (!sel_prot && wf_s.fail) |=> trail_fail_action_o)
    else $error("trail fail action missed server fail");
  chk_nonrev_no_wtr: assert property (@(posedge clk_i) disable iff
    (rst_i) !revert_mode_select |=> !wtr_run)
    else $error("wait-to-restore ran in non-revertive mode");
  chk_hold_bound: assert property (@(posedge clk_i) disable iff
    (rst_i) holdoff_delay <= HOLD_MAX)
    else $error("hold-off exceeds ten seconds");
  chk_rev_cmd_filter: assert property (@(posedge clk_i) disable iff
    (rst_i) (cmd_pulse && revert_mode_select
    && external_command inside {CMD_FORCE_W, CMD_MAN_W, CMD_DRILL_W,
    CMD_DRILL_P}) |=> held_cmd == $past(held_cmd))
    else $error("revertive mode accepted a working-side command");
  chk_sel_to_norm: assert property (@(posedge clk_i) disable iff
    (rst_i) sel_prot |=> norm_out_o == $past(prot_s))
    else $error("normal output not from protection");
endmodule : vc12_prot

// File: bench/vc12_far_end.sv
// far-end model: drives the working and protection access inputs
// assumes the block samples these pins with its own clock
`timescale 1ns/10ps
module vc12_far_end
  import vc12_prot_pkg::*;
(
  // protocol nibble that the far end sends
  input  wire logic [3:0] far_nib_i,
  // access-point streams toward the block
  output path_sig_t       work_o,
  output path_sig_t       prot_o
);
  logic       lclk = 1'b0;
  logic [7:0] cnt  = 8'h00;
  // path clock runs free, unrelated in phase to the block clock
  always #62.5 lclk = ~lclk;
  // payload counter, one byte per path clock
  always @(posedge lclk) cnt <= cnt + 8'h01;
  // protection carries the inverse payload so the selection shows
  always_comb begin
    work_o = '{data: cnt, clk: lclk, frame: cnt[2:0] == 3'h0};
    prot_o = '{data: ~cnt, clk: lclk, frame: cnt[2:0] == 3'h0};
    if (prot_o.frame) prot_o.data[7:4] = far_nib_i;
  end
endmodule : vc12_far_end

// File: bench/vc12_prot_tb.sv
// bench for the trail protection block: register rows, path checks
// assumes the far-end model drives both access inputs
`timescale 1ns/10ps
`define CMP(n, e, g) begin samples_checked++; \
  if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module vc12_prot_tb
  import vc12_prot_pkg::*;
;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [7:0]  ra;
    logic [31:0] m;
    logic [31:0] e;
  } row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, q;
  logic        ack_o, irq_o, norm_fail_o, tfa, sfr;
  path_sig_t   norm_in_i = '0;
  path_sig_t   norm_out_o, work_in_i, work_out_o, prot_in_i, prot_out_o;
  path_flags_t work_flags_i = '0;
  path_flags_t prot_flags_i = '0;
  logic [3:0]  far_nib = 4'h0;
  path_sig_t   whist [3];
  path_sig_t   phist [3];
  logic [1:0]  mon = 2'h0;
  row_t        rows [20];
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // ---------------------------------------------------------------
  // design and far end
  // ---------------------------------------------------------------
  vc12_prot vc12_prot_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .norm_in_i(norm_in_i), .norm_out_o(norm_out_o),
    .norm_fail_o(norm_fail_o), .work_in_i(work_in_i),
    .work_flags_i(work_flags_i), .work_out_o(work_out_o),
    .prot_in_i(prot_in_i), .prot_flags_i(prot_flags_i),
    .prot_out_o(prot_out_o), .trail_fail_action_o(tfa),
    .server_fail_report_o(sfr));
  vc12_far_end vc12_far_end_inst (.far_nib_i(far_nib),
    .work_o(work_in_i), .prot_o(prot_in_i));

  // clock, timeout, and a watch on the forwarded traffic
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      give_verdict();
    end
  end
  // output leaves three clocks after the pin sample
  always @(posedge clk_i) begin
    if (mon == 2'h1) `CMP("norm_w", whist[2], norm_out_o)
    if (mon == 2'h2) `CMP("norm_p", phist[2], norm_out_o)
    whist <= '{work_in_i, whist[0], whist[1]};
    phist <= '{prot_in_i, phist[0], phist[1]};
  end

  // ---------------------------------------------------------------
  // bus access and verdict
  // ---------------------------------------------------------------
  // one classic cycle; only the bench timeout ends a wait on a dead slave
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    `CMP("ack", 1'b1, ack_o)
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    // write address, write data, read address, mask, expected
    rows = '{
      '{REG_WTR, 32'h64, REG_WTR, 32'hFFFF, 32'h12C},
      '{REG_WTR, 32'h1F4, REG_WTR, 32'hFFFF, 32'h1F4},
      '{REG_WTR, 32'h320, REG_WTR, 32'hFFFF, 32'h2D0},
      '{REG_HOLD, 32'h78, REG_HOLD, 32'h7F, 32'h64},
      '{REG_HOLD, 32'h0, REG_HOLD, 32'h7F, 32'h0},
      '{REG_IRQ_EN, 32'hF, REG_IRQ_EN, 32'hF, 32'hF},
      '{8'h30, 32'h5, 8'h30, 32'hFFFF_FFFF, 32'h0},
      '{REG_APS_TX, 32'hA, REG_APS_TX, 32'hF, 32'hA},
      '{REG_CTRL, 32'h0, REG_CTRL, 32'h3, 32'h0},
      '{REG_CTRL, 32'h1, REG_CTRL, 32'h3, 32'h1},
      '{REG_CMD, 32'h2, REG_STATUS, 32'h2, 32'h2},
      '{REG_CMD, 32'h5, REG_STATUS, 32'h2, 32'h2},
      '{REG_CTRL, 32'h0, REG_STATUS, 32'h2, 32'h2},
      '{REG_CMD, 32'h5, REG_STATUS, 32'h2, 32'h0},
      '{REG_CMD, 32'h4, REG_STATUS, 32'h2, 32'h2},
      '{REG_CMD, 32'h3, REG_STATUS, 32'h2, 32'h0},
      '{REG_CMD, 32'h7, REG_STATUS, 32'h2, 32'h0},
      '{REG_CMD, 32'h6, REG_STATUS, 32'h2, 32'h0},
      '{REG_CMD, 32'h2, REG_STATUS, 32'h2, 32'h2},
      '{REG_CMD, 32'h1, REG_STATUS, 32'h2, 32'h0}};
    repeat (16) @(posedge clk_i);
    `CMP("rst_norm", 10'h0, norm_out_o)
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, REG_CTRL, 32'h0);
    `CMP("ctrl_rst", 32'h1, q & 32'h3)
    mon <= 2'h1;
    for (int i = 0; i < 20; i++) begin
      if (i == 10) mon <= 2'h0;
      wb(1'b1, rows[i].a, rows[i].d);
      wb(1'b0, rows[i].ra, 32'h0);
      `CMP("row", rows[i].e, q & rows[i].m)
    end
    // lift the lockout left by the rows so a failure can move the selector
    wb(1'b1, REG_CMD, 32'h0);
    // bridge onto both outputs, channel nibble inserted with frame held high
    wb(1'b1, REG_IRQ_CLR, 32'hF);
    norm_in_i <= '{data: 8'h5A, clk: 1'b1, frame: 1'b1};
    repeat (4) @(posedge clk_i);
    `CMP("irq_clr", 1'b0, irq_o)
    `CMP("work_out", 10'h16B, work_out_o)
    `CMP("prot_frm", 8'hAA, prot_out_o.data)
    // working path fails: selector moves, event raises the interrupt
    work_flags_i <= '{fail: 1'b1, degrade: 1'b0};
    for (int n = 0; n < 40 && irq_o !== 1'b1; n++) @(posedge clk_i);
    `CMP("irq_sw", 1'b1, irq_o)
    repeat (3) @(posedge clk_i);
    mon <= 2'h2;
    repeat (10) @(posedge clk_i);
    mon <= 2'h0;
    `CMP("tfa_p_ok", 1'b0, tfa)
    `CMP("nfail_p", 1'b0, norm_fail_o)
    wb(1'b0, REG_STATUS, 32'h0);
    `CMP("status", 32'h6, q & 32'h6)
    // both paths fail: the protected trail reports its failure
    prot_flags_i <= '{fail: 1'b1, degrade: 1'b0};
    repeat (6) @(posedge clk_i);
    `CMP("tfa_all", 1'b1, tfa)
    `CMP("nfail_all", 1'b1, norm_fail_o)
    `CMP("rep_off", 1'b0, sfr)
    wb(1'b1, REG_CTRL, 32'h2);
    repeat (2) @(posedge clk_i);
    `CMP("rep_on", 1'b1, sfr)
    work_flags_i <= '0;
    prot_flags_i <= '0;
    // far nibble is accepted only after repeated equal frames
    far_nib <= 4'h6;
    repeat (700) @(posedge clk_i);
    wb(1'b0, REG_APS_RX, 32'h0);
    `CMP("aps_rx", 32'h6, q & 32'hF)
    wb(1'b0, REG_IRQ_ST, 32'h0);
    `CMP("irq_aps", 32'h8, q & 32'h8)
    // second reset in mid-run
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CMP("irq_rst", 1'b0, irq_o)
    wb(1'b0, REG_WTR, 32'h0);
    `CMP("wtr_rst", 32'h12C, q & 32'hFFFF)
    give_verdict();
  end
endmodule : vc12_prot_tb
